/* File: shared/tsc_pkg.sv */
`default_nettype none
package tsc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // control field positions
  localparam int CTRL_SHUTDOWN_BIT = 0;
  localparam int CTRL_ONE_SHOT_BIT = 1;
  localparam int CTRL_RES_LO_BIT = 2;
  localparam int CTRL_RES_HI_BIT = 3;
  // status field positions
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_SHOT_BIT = 2;
  // interrupt bits
  localparam int IRQ_W = 2;
  localparam int IRQ_CONV_BIT = 0;
  localparam int IRQ_SHOT_BIT = 1;
  // result values
  localparam logic [15:0] RESULT_RESET = 16'h7FFC;
  localparam logic [15:0] RESULT_SENTINEL = 16'h8000;
  localparam logic [15:0] LOW_MASK_BASE = 16'h001F;
  localparam logic [15:0] ONE_DEGREE = 16'h0080;
  localparam int RAW_W = 14;
  localparam logic [RAW_W-1:0] RAW_ONE_DEGREE = 14'h0020;
  // timing: 11-bit conversion time, doubled per resolution step
  localparam int CLK_KHZ = 40000;
  localparam int CONV_TIME_US = 14000;
  localparam int CONV_BASE_CYCLES_DEF = CONV_TIME_US * CLK_KHZ / 1000;
  localparam int CNT_W = 24;

  typedef struct packed {
    logic resolution_select_hi;
    logic resolution_select_lo;
    logic one_shot;
    logic shutdown;
  } tsc_ctrl_type;

  typedef struct packed {
    logic hsel;
    logic hready;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } tsc_ahb_req_type;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } tsc_ahb_rsp_type;
endpackage
`default_nettype wire

/* File: core/tsc_conv_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module tsc_conv_timer #(
  parameter int unsigned BASE = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic [1:0] res,
  output logic busy,
  output logic done
);
  import tsc_pkg::*;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  // conversion time doubles with each extra result bit
  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (abort)
    begin
      busy_d = 1'b0;
    end
    else if (busy_q)
    begin
      if (cnt_q <= CNT_W'(1))
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
    else if (start)
    begin
      busy_d = 1'b1;
      cnt_d = CNT_W'(BASE) << res;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
endmodule // tsc_conv_timer
`default_nettype wire

/* File: core/tsc_formatter.sv */
`timescale 1ns/1ps
`default_nettype none
module tsc_formatter (
  input wire logic [tsc_pkg::RAW_W-1:0] raw,
  input wire logic [1:0] res,
  output logic [15:0] word
);
  import tsc_pkg::*;
  // left justify, then clear bits under the chosen lsb
  always_comb
  begin
    word = {raw, 2'b00} & ~(LOW_MASK_BASE >> res);
  end
endmodule // tsc_formatter
`default_nettype wire

/* File: core/tsc_result_ctrl.sv */
// Operation
// - after reset every register keeps its reset value until conversion or host write
// - first completed conversion updates the result and status bits
// - in shutdown a written one-shot bit runs exactly one conversion; here only when the same write keeps the shutdown bit set
// - during a one-shot the valid flag is zero and result reads 8000h
// - during a one-shot all other registers keep their previous contents
// - one-shot end sets the valid flag and loads the measured result
// - two-bit resolution field selects 11 to 14 result bits
// - default resolution is 11 bits, a quarter degree per lsb
// - result is left-justified two's complement, one degree reads 0080h
// - result bits below the selected lsb read as zero
// - result register holds 7FFCh from reset until first conversion
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tsc_result_ctrl #(
  parameter int unsigned CONV_BASE_CYCLES = tsc_pkg::CONV_BASE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire tsc_pkg::tsc_ahb_req_type ahb_req,
  output tsc_pkg::tsc_ahb_rsp_type ahb_rsp,
  input wire logic [tsc_pkg::RAW_W-1:0] adc_sample,
  output logic irq
);
  import tsc_pkg::*;

  typedef enum logic [1:0] {ST_CONT, ST_SHUT, ST_SHOT} tsc_state_type;

  ////////////////////////////////////////////////////////////////
  // state
  tsc_state_type state_q, state_d;
  tsc_ctrl_type ctrl_q, ctrl_d;
  logic [15:0] result_q, result_d;
  logic valid_q, valid_d;
  logic first_done_q, first_done_d;
  logic [1:0] conv_res_q, conv_res_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic irq_q, irq_d;
  logic dp_wr_q, dp_wr_d;
  logic [7:0] dp_addr_q, dp_addr_d;
  tsc_ahb_rsp_type rsp_q, rsp_d;

  logic ap_valid;
  logic wr_fire;
  logic ctrl_wr;
  logic shot_trig;
  logic tmr_start;
  logic tmr_abort;
  logic tmr_busy;
  logic tmr_done;
  logic [1:0] res_now;
  logic [15:0] fmt_word;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] w1c;

  ////////////////////////////////////////////////////////////////
  // leaves
  tsc_conv_timer #(
    .BASE(CONV_BASE_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(tmr_start),
    .abort(tmr_abort),
    .res(res_now),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  tsc_formatter u_fmt (
    .raw(adc_sample),
    .res(conv_res_q),
    .word(fmt_word)
  );

  ////////////////////////////////////////////////////////////////
  // bus decode
  assign ap_valid = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
  assign wr_fire = dp_wr_q;
  assign ctrl_wr = wr_fire && (dp_addr_q == OFS_CTRL);
  assign res_now = {ctrl_q.resolution_select_hi, ctrl_q.resolution_select_lo};

  // one-shot only honoured in shutdown with shutdown kept set
  assign shot_trig = ctrl_wr && (state_q == ST_SHUT)
    && ahb_req.hwdata[CTRL_ONE_SHOT_BIT]
    && ahb_req.hwdata[CTRL_SHUTDOWN_BIT];

  assign tmr_start = shot_trig
    || ((state_q == ST_CONT) && !ctrl_q.shutdown && !tmr_busy);
  assign tmr_abort = (state_q == ST_CONT) && ctrl_q.shutdown;

  ////////////////////////////////////////////////////////////////
  // conversion control and result
  always_comb
  begin
    state_d = state_q;
    result_d = result_q;
    valid_d = valid_q;
    first_done_d = first_done_q;
    conv_res_d = conv_res_q;
    irq_evt = '0;
    if (tmr_start)
    begin
      conv_res_d = res_now;
    end
    unique case (state_q)
      ST_CONT:
      begin
        if (tmr_done)
        begin
          result_d = fmt_word;
          valid_d = 1'b1;
          first_done_d = 1'b1;
          irq_evt[IRQ_CONV_BIT] = 1'b1;
        end
        if (ctrl_q.shutdown)
        begin
          state_d = ST_SHUT;
        end
      end
      ST_SHUT:
      begin
        if (shot_trig)
        begin
          state_d = ST_SHOT;
          result_d = RESULT_SENTINEL;
          valid_d = 1'b0;
        end
        else if (!ctrl_q.shutdown)
        begin
          state_d = ST_CONT;
        end
      end
      ST_SHOT:
      begin
        if (tmr_done)
        begin
          state_d = ST_SHUT;
          result_d = fmt_word;
          valid_d = 1'b1;
          first_done_d = 1'b1;
          irq_evt[IRQ_CONV_BIT] = 1'b1;
          irq_evt[IRQ_SHOT_BIT] = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_CONT;
      result_q <= RESULT_RESET;
      valid_q <= 1'b0;
      first_done_q <= 1'b0;
      conv_res_q <= 2'b00;
    end
    else
    begin
      state_q <= state_d;
      result_q <= result_d;
      valid_q <= valid_d;
      first_done_q <= first_done_d;
      conv_res_q <= conv_res_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // software registers and interrupt
  always_comb
  begin
    ctrl_d = ctrl_q;
    irq_mask_d = irq_mask_q;
    w1c = '0;
    // one-shot reads back as pending, never stored
    ctrl_d.one_shot = (state_d == ST_SHOT);
    if (ctrl_wr)
    begin
      ctrl_d.shutdown = ahb_req.hwdata[CTRL_SHUTDOWN_BIT];
      ctrl_d.resolution_select_lo = ahb_req.hwdata[CTRL_RES_LO_BIT];
      ctrl_d.resolution_select_hi = ahb_req.hwdata[CTRL_RES_HI_BIT];
    end
    if (wr_fire && (dp_addr_q == OFS_IRQ_MASK))
    begin
      irq_mask_d = ahb_req.hwdata[IRQ_W-1:0];
    end
    if (wr_fire && (dp_addr_q == OFS_IRQ_STAT))
    begin
      w1c = ahb_req.hwdata[IRQ_W-1:0];
    end
    // a new event beats a clear in the same cycle
    irq_stat_d = (irq_stat_q & ~w1c) | irq_evt;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_q <= '0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  always_comb
  begin
    dp_wr_d = ap_valid && ahb_req.hwrite;
    dp_addr_d = ap_valid ? ahb_req.haddr[7:0] : dp_addr_q;
    rsp_d.hreadyout = 1'b1;
    rsp_d.hresp = 1'b0;
    rsp_d.hrdata = rsp_q.hrdata;
    if (ap_valid && !ahb_req.hwrite)
    begin
      rsp_d.hrdata = '0;
      unique case (ahb_req.haddr[7:0])
        OFS_CTRL: rsp_d.hrdata[3:0] = ctrl_q;
        OFS_RESULT: rsp_d.hrdata[15:0] = result_q;
        OFS_STATUS:
        begin
          rsp_d.hrdata[STAT_VALID_BIT] = valid_q;
          rsp_d.hrdata[STAT_BUSY_BIT] = tmr_busy;
          rsp_d.hrdata[STAT_SHOT_BIT] = (state_q == ST_SHOT);
        end
        OFS_IRQ_STAT: rsp_d.hrdata[IRQ_W-1:0] = irq_stat_q;
        OFS_IRQ_MASK: rsp_d.hrdata[IRQ_W-1:0] = irq_mask_q;
        default: rsp_d.hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= '0;
      rsp_q <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000};
    end
    else
    begin
      dp_wr_q <= dp_wr_d;
      dp_addr_q <= dp_addr_d;
      rsp_q <= rsp_d;
    end
  end

  assign ahb_rsp = rsp_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence shot_start_s;
    state_q == ST_SHUT && shot_trig;
  endsequence

  sequence shot_end_s;
    state_q == ST_SHOT && tmr_done;
  endsequence

  sequence cont_end_s;
    state_q == ST_CONT && tmr_done;
  endsequence

  sequence cont_abort_s;
    state_q == ST_CONT && ctrl_q.shutdown && !tmr_done;
  endsequence

  chk_reset_hold: assert property (!first_done_q |-> result_q == RESULT_RESET || state_q == ST_SHOT)
    else $error("result left reset value before a conversion");

  chk_first_update: assert property (cont_end_s |=> result_q == $past(fmt_word) && valid_q && first_done_q)
    else $error("conversion end did not update result");

  chk_shot_start: assert property (shot_start_s |=> state_q == ST_SHOT && tmr_busy)
    else $error("one-shot write did not start a conversion");

  chk_shot_once: assert property (shot_end_s |=> state_q == ST_SHUT ##1 !tmr_busy)
    else $error("one-shot ran more than one conversion");

  chk_shot_sentinel: assert property (state_q == ST_SHOT |-> result_q == RESULT_SENTINEL && !valid_q)
    else $error("one-shot state shows wrong result or valid flag");

  chk_shot_keeps: assert property (state_q == ST_SHOT && !wr_fire && !tmr_done |=> $stable(irq_mask_q) && $stable(res_now) && $stable(irq_stat_q))
    else $error("register changed during one-shot");

  chk_shot_done: assert property (shot_end_s |=> valid_q && result_q == $past(fmt_word) && irq_stat_q[IRQ_SHOT_BIT])
    else $error("one-shot end did not load result");

  // a loaded result uses the resolution latched at its start
  chk_res_lsbs: assert property (tmr_done |=> (result_q & (LOW_MASK_BASE >> $past(conv_res_q))) == 16'h0000)
    else $error("result bits under lsb not zero");

  chk_default_res: assert property ($rose(first_done_q) && $past(res_now, 2) == 2'b00 |-> conv_res_q == 2'b00)
    else $error("default resolution not eleven bits");

  chk_one_degree: assert property (adc_sample == RAW_ONE_DEGREE |-> fmt_word == ONE_DEGREE)
    else $error("one degree does not read 0080h");

  chk_cont_ignore: assert property (state_q == ST_CONT |=> state_q != ST_SHOT)
    else $error("one-shot accepted outside shutdown");

  chk_irq_level: assert property (irq == |(irq_stat_q & irq_mask_q))
    else $error("interrupt output wrong");

  chk_set_wins: assert property ((|irq_evt) |=> (irq_stat_q & $past(irq_evt)) == $past(irq_evt))
    else $error("status event lost to a clear");

  chk_abort_clean: assert property (cont_abort_s |=> !tmr_busy && $stable(result_q))
    else $error("aborted conversion changed the result");

  chk_cont_restart: assert property (state_q == ST_CONT && !ctrl_q.shutdown && tmr_done |=> tmr_busy)
    else $error("continuous conversion did not restart");

  chk_shot_refused: assert property (ctrl_wr && state_q == ST_CONT |=> !ctrl_q.one_shot && !$fell(valid_q))
    else $error("one-shot write taken outside shutdown");

  chk_valid_sticky: assert property (valid_q && !shot_trig |=> valid_q)
    else $error("valid flag dropped without a one-shot");

  chk_bus_okay: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
    else $error("bus response not ready and okay");

  chk_hrdata_hold: assert property (!ap_valid || ahb_req.hwrite |=> $stable(ahb_rsp.hrdata))
    else $error("read data changed without a read");
endmodule // tsc_result_ctrl
`default_nettype wire

/* File: dv/tsc_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tsc_sensor_model
(
  input wire logic clk,
  input wire logic [tsc_pkg::RAW_W-1:0] temp_in,
  output logic [tsc_pkg::RAW_W-1:0] adc_sample
);
  // the converter front end presents a registered die temperature
  always_ff @(posedge clk)
  begin
    adc_sample <= temp_in;
  end
endmodule // tsc_sensor_model
`default_nettype wire

/* File: dv/temp_conversion_result_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module temp_conversion_result_ctrl_test;
  import tsc_pkg::*;
  logic clk;
  logic rst_n;
  tsc_ahb_req_type m;
  tsc_ahb_req_type req;
  tsc_ahb_rsp_type rsp;
  logic [RAW_W-1:0] temp;
  logic [RAW_W-1:0] adc;
  logic [RAW_W-1:0] raw;
  logic irq;
  logic [31:0] rd;
  logic [31:0] xs;
  int n_mismatch;
  int total_checks;
  int cyc;
  int r;

  assign req = {m[71], rsp.hreadyout, m[69:0]};

  tsc_result_ctrl #(.CONV_BASE_CYCLES(8)) uut (.clk(clk), .rst_n(rst_n), .ahb_req(req), .ahb_rsp(rsp),
    .adc_sample(adc), .irq(irq));
  tsc_sensor_model sensor (.clk(clk), .temp_in(temp), .adc_sample(adc));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // reference result word: left-justified, only the top 11+res bits kept
  function automatic logic [31:0] fmt(logic [RAW_W-1:0] v, int res);
    return {16'h0000, {v, 2'b00} & (16'hFFFF << (5 - res))};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_word(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(logic got, logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: irq %b expected %b", $time, got, exp);
    end
  endtask

  // one single AHB transfer; waits on hready at both phases
  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
    m.hsel <= 1'b1;
    m.htrans <= 2'b10;
    m.haddr <= {24'h000000, a};
    m.hwrite <= wr;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    m.htrans <= 2'b00;
    m.hwdata <= d;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask

  task automatic rd_chk(logic [7:0] a, logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask

  task automatic wait_irq();
    int i;
    @(posedge clk);
    for (i = 0; i < 300 && irq !== 1'b1; i++)
      @(posedge clk);
    chk_bit(irq, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  initial
  begin
    m = '0;
    m.hsize = 3'b010;
    rst_n = 1'b0;
    temp = '0;
    xs = 32'h14724B01;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(OFS_RESULT, {16'h0000, RESULT_RESET});
    rd_chk(OFS_CTRL, 32'h0);
    xfer(1'b1, OFS_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    xfer(1'b1, OFS_IRQ_STAT, 32'h3);
    xfer(1'b1, OFS_IRQ_MASK, 32'h2);
    for (r = 0; r < 4; r++)
    begin
      xs = xorshift(xs);
      raw = (r == 0) ? RAW_ONE_DEGREE : xs[RAW_W-1:0];
      temp <= raw;
      xfer(1'b1, OFS_CTRL, {28'h0, r[1:0], 2'b01});
      xfer(1'b1, OFS_CTRL, {28'h0, r[1:0], 2'b11});
      rd_chk(OFS_RESULT, {16'h0000, RESULT_SENTINEL});
      rd_chk(OFS_STATUS, 32'h6);
      rd_chk(OFS_CTRL, {28'h0, r[1:0], 2'b11});
      rd_chk(OFS_IRQ_MASK, 32'h2);
      wait_irq();
      rd_chk(OFS_RESULT, fmt(raw, r));
      rd_chk(OFS_STATUS, 32'h1);
      rd_chk(OFS_IRQ_STAT, 32'h3);
      xfer(1'b1, OFS_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk_bit(irq, 1'b0);
      xfer(1'b1, OFS_IRQ_STAT, 32'h3);
      xfer(1'b1, OFS_IRQ_MASK, 32'h2);
      repeat (40) @(posedge clk);
      rd_chk(OFS_IRQ_STAT, 32'h0);
    end
    xfer(1'b1, OFS_CTRL, 32'h0);
    xfer(1'b1, OFS_IRQ_MASK, 32'h1);
    repeat (12) @(posedge clk);
    xs = xorshift(xs);
    raw = xs[RAW_W-1:0];
    temp <= raw;
    xfer(1'b1, OFS_IRQ_STAT, 32'h3);
    wait_irq();
    rd_chk(OFS_RESULT, fmt(raw, 0));
    xfer(1'b1, OFS_CTRL, 32'h2);
    rd_chk(OFS_RESULT, fmt(raw, 0));
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk_word(rd & 32'h5, 32'h1);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_bit(irq, 1'b0);
    rd_chk(OFS_RESULT, {16'h0000, RESULT_RESET});
    rd_chk(OFS_STATUS, 32'h2);
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(8'h20, 32'h0);
    stop_test();
  end
endmodule // temp_conversion_result_ctrl_test
`default_nettype wire
